/* verilog/temp_monitor_consts.vh */
`ifndef TEMP_MONITOR_CONSTS_VH
`define TEMP_MONITOR_CONSTS_VH
// ****************************************************************
// command codes seen on the byte-level command port
// ****************************************************************
`define CMD_LOCAL_TEMP_READ 8'h00
`define CMD_REMOTE_TEMP_READ 8'h01
`define CMD_STATUS_READ 8'h02
`define CMD_CONFIG_READ 8'h03
`define CMD_RATE_READ 8'h04
`define CMD_LOCAL_HIGH_READ 8'h05
`define CMD_LOCAL_LOW_READ 8'h06
`define CMD_REMOTE_HIGH_READ 8'h07
`define CMD_REMOTE_LOW_READ 8'h08
`define CMD_CONFIG_WRITE 8'h09
`define CMD_RATE_WRITE 8'h0a
`define CMD_LOCAL_HIGH_WRITE 8'h0b
`define CMD_LOCAL_LOW_WRITE 8'h0c
`define CMD_REMOTE_HIGH_WRITE 8'h0d
`define CMD_REMOTE_LOW_WRITE 8'h0e
`define CMD_SINGLE_CONVERSION 8'h0f
// ****************************************************************
// reset values
// ****************************************************************
`define RST_RATE 3'h2
`define RST_HIGH_LIMIT 8'h7f
`define RST_LOW_LIMIT 8'hc9
`define RST_TEMP 8'h00
`define RST_BYTE 8'h00
// ****************************************************************
// field positions
// ****************************************************************
`define CFG_MASK_BIT 7
`define CFG_HARD_STANDBY_PIN_BIT 6
`define ST_BUSY_BIT 7
`define ST_LHI_BIT 6
`define ST_LLO_BIT 5
`define ST_RHI_BIT 4
`define ST_RLO_BIT 3
`define ST_OPEN_BIT 2
`define RATE_W 3
// ****************************************************************
// fixed values
// ****************************************************************
`define ALERT_RESP_ADDR 7'h0c
`define FAULT_REMOTE_TEMP 8'h7f
`define FLAGS_NONE 5'h00
`define BASE_PERIOD_S 16
`define CONV_TIME_MS 170
`define CLK_HZ 125000000
`endif

/* verilog/pin_sync.v */
`timescale 1ns/1ps
// ****************************************************************
// three-stage pin synchroniser with agreement filter
// ****************************************************************
module pin_sync #(
  parameter RST_VAL = 1'b0
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_pin,
  output wire o_level
);
  reg s1_q; // first stage, read only by s2
  reg s2_q; // second stage
  reg s3_q; // third stage
  reg lvl_q; // accepted level
  // shift chain; a change is taken once stages two and three agree
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      lvl_q <= RST_VAL;
    end else begin
      s1_q <= i_pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        lvl_q <= s3_q;
      end
    end
  end
  assign o_level = lvl_q;
endmodule

/* verilog/limit_compare.v */
`timescale 1ns/1ps
// ****************************************************************
// signed limit comparison for one channel
// ****************************************************************
module limit_compare (
  input wire [7:0] i_result,
  input wire [7:0] i_high,
  input wire [7:0] i_low,
  output wire o_high_trip,
  output wire o_low_trip
);
  // equal counts as tripped on both sides
  assign o_high_trip = ($signed(i_result) >= $signed(i_high)); // see [RULE25]
  assign o_low_trip = ($signed(i_result) <= $signed(i_low)); // see [RULE25]
endmodule

/* verilog/temp_monitor_limit_alert.v */
`timescale 1ns/1ps
`include "temp_monitor_consts.vh"
// Summary of operation
// [RULE1] results are signed bytes, one degree each
// [RULE2] rate code uses three bits, 1/16 to 8 Hz
// [RULE3] rate code two after reset
// [RULE4] compare each result with limits, flag, alert
// [RULE5] high limits 127, low limits -55 at reset
// [RULE6] each limit has own write and read command
// [RULE7] send byte 0fh starts a conversion
// [RULE8] running mode one-shot starts now unless busy
// [RULE9] software standby one-shot converts once then idles
// [RULE10] hardware standby blocks one-shot conversions
// [RULE11] status bit 7 high while converting
// [RULE12] bits 6..3 local hi, lo, remote hi, lo
// [RULE13] bit 2 open diode, bits 1..0 zero
// [RULE14] reset clears flags; status is read only
// [RULE15] status read clears flags unless fault persists
// [RULE16] every flag except busy raises alert
// [RULE17] alert active low, open drain
// [RULE18] alert latched until alert response read
// [RULE19] alert response returns address, bit0 one
// [RULE20] response read releases alert unless fault persists
// [RULE21] host waits about 170 ms before status read
// [RULE22] config bit7 masks alert, bit6 software standby
// [RULE23] hardware standby aborts conversion, results kept
// [RULE24] diode fault stores 127, sets flags, alerts
// [RULE25] signed compare, equal trips both limits
module temp_monitor_limit_alert #(
  parameter BASE_PERIOD_CYCLES = `CLK_HZ * `BASE_PERIOD_S, // 16 s at code zero
  parameter CONV_CYCLES = (`CLK_HZ / 1000) * `CONV_TIME_MS // one conversion
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_wr_strobe,
  input wire [7:0] i_wr_cmd,
  input wire [7:0] i_wr_data,
  input wire i_send_strobe,
  input wire [7:0] i_send_cmd,
  input wire i_rd_strobe,
  input wire [7:0] i_rd_cmd,
  input wire i_ara_strobe,
  input wire [6:0] i_slave_addr,
  output wire [7:0] o_rd_data,
  output wire o_rd_valid,
  output wire o_ara_ack,
  input wire [7:0] i_local_sample,
  input wire [7:0] i_remote_sample,
  input wire i_diode_open,
  input wire i_diode_short,
  input wire i_hard_standby_pin_n,
  output wire o_conv_start,
  output wire o_alert_o,
  output wire o_alert_oe_n,
  output wire [7:0] o_local_temp_result,
  output wire [7:0] o_remote_temp_result
);
  // ****************************************************************
  // declarations
  // ****************************************************************
  localparam ST_IDLE = 1'b0; // no conversion running
  localparam ST_BUSY = 1'b1; // conversion in progress
  reg state_q; // converter state
  reg state_d;
  reg [31:0] rate_cnt_q; // interval timer between automatic conversions
  reg [31:0] rate_cnt_d;
  reg [31:0] conv_cnt_q; // cycles spent in the running conversion
  reg [31:0] conv_cnt_d;
  reg [`RATE_W-1:0] rate_q; // conversion rate code
  reg [7:0] loc_hi_q; // local high limit
  reg [7:0] loc_lo_q; // local low limit
  reg [7:0] rem_hi_q; // remote high limit
  reg [7:0] rem_lo_q; // remote low limit
  reg cfg_mask_q; // alert mask
  reg cfg_hard_standby_pin_q; // software standby
  reg [7:0] loc_temp_q; // local result
  reg [7:0] rem_temp_q; // remote result
  reg [7:0] loc_temp_d;
  reg [7:0] rem_temp_d;
  reg open_cap_q; // open fault caught at conversion start
  reg short_cap_q; // short fault caught at conversion start
  reg [4:0] flags_q; // latched flags, bits 6..2 of status
  reg [4:0] flags_d;
  reg [4:0] cond_q; // conditions seen by the last conversion
  reg [4:0] cond_d;
  reg alert_q; // alert latch
  reg alert_d;
  reg [7:0] rd_data_q; // read answer
  reg rd_valid_q;
  reg ara_ack_q;
  wire hard_hard_standby_pin_n; // synchronised standby pin, low means standby
  wire diode_open; // synchronised open fault
  wire diode_short; // synchronised short fault
  wire loc_hi_trip;
  wire loc_lo_trip;
  wire rem_hi_trip;
  wire rem_lo_trip;
  wire [7:0] rem_eff; // remote value after fault substitution
  wire oneshot; // single conversion command seen
  wire auto_due; // automatic interval expired
  wire start; // conversion begins this cycle
  wire conv_done; // conversion completes this cycle
  wire [4:0] set_evt; // flags set at completion
  wire status_rd; // status byte read this cycle
  wire [7:0] status_byte;

  // ****************************************************************
  // helpers
  // ****************************************************************
  // interval length for a rate code; each step halves the interval
  function [31:0] rate_period;
    input [`RATE_W-1:0] code;
    begin
      rate_period = BASE_PERIOD_CYCLES >> code; // see [RULE2]
    end
  endfunction

  // ****************************************************************
  // pin inputs
  // ****************************************************************
  // standby pin idles high so the device runs out of reset
  pin_sync #(
    .RST_VAL(1'b1)
  ) u_sync_hard_standby_pin (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_pin(i_hard_standby_pin_n),
    .o_level(hard_hard_standby_pin_n)
  );
  pin_sync #(
    .RST_VAL(1'b0)
  ) u_sync_open (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_pin(i_diode_open),
    .o_level(diode_open)
  );
  pin_sync #(
    .RST_VAL(1'b0)
  ) u_sync_short (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_pin(i_diode_short),
    .o_level(diode_short)
  );

  // ****************************************************************
  // conversion sequencing
  // ****************************************************************
  assign oneshot = i_send_strobe && (i_send_cmd == `CMD_SINGLE_CONVERSION); // see [RULE7]
  assign auto_due = !cfg_hard_standby_pin_q && (rate_cnt_q >= rate_period(rate_q) - 32'h1);
  // one-shot is refused while busy or in hardware standby
  assign start = (state_q == ST_IDLE) && hard_hard_standby_pin_n && // see [RULE10]
    (oneshot || auto_due); // see [RULE8]
  assign conv_done = (state_q == ST_BUSY) && hard_hard_standby_pin_n && (conv_cnt_q >= CONV_CYCLES - 1);
  assign o_conv_start = start;

  // next state of sequencer and timers
  always @* begin
    state_d = state_q;
    conv_cnt_d = conv_cnt_q;
    rate_cnt_d = rate_cnt_q;
    case (state_q)
      ST_IDLE: begin
        conv_cnt_d = 32'h0;
        // timer only runs in free-running mode; standby clears it to zero
        if (cfg_hard_standby_pin_q || !hard_hard_standby_pin_n) begin
          rate_cnt_d = 32'h0;
        end else begin
          rate_cnt_d = rate_cnt_q + 32'h1;
        end
        if (start) begin
          state_d = ST_BUSY; // see [RULE9]
          rate_cnt_d = 32'h0;
        end
      end
      ST_BUSY: begin
        conv_cnt_d = conv_cnt_q + 32'h1;
        // keep timing through the conversion so the interval is start to start
        rate_cnt_d = rate_cnt_q + 32'h1; // see [RULE2]
        if (!hard_hard_standby_pin_n) begin
          state_d = ST_IDLE; // see [RULE23]
        end else if (conv_done) begin
          state_d = ST_IDLE; // software standby stays idle afterwards, see [RULE9]
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // comparison
  // ****************************************************************
  // a faulty diode reads as full scale
  assign rem_eff = (open_cap_q || short_cap_q) ? `FAULT_REMOTE_TEMP : i_remote_sample; // see [RULE24]
  limit_compare u_cmp_loc (
    .i_result(i_local_sample),
    .i_high(loc_hi_q),
    .i_low(loc_lo_q),
    .o_high_trip(loc_hi_trip),
    .o_low_trip(loc_lo_trip)
  );
  limit_compare u_cmp_rem (
    .i_result(rem_eff),
    .i_high(rem_hi_q),
    .i_low(rem_lo_q),
    .o_high_trip(rem_hi_trip),
    .o_low_trip(rem_lo_trip)
  );
  // order matches status bits 6..2; faults also set the remote high flag
  assign set_evt = conv_done ? {loc_hi_trip, loc_lo_trip,
                                rem_hi_trip | open_cap_q | short_cap_q, rem_lo_trip,
                                open_cap_q} : `FLAGS_NONE; // see [RULE4]

  // ****************************************************************
  // status, alert and results
  // ****************************************************************
  assign status_rd = i_rd_strobe && (i_rd_cmd == `CMD_STATUS_READ);
  assign status_byte = {(state_q == ST_BUSY), flags_q, 2'b00}; // see [RULE11] [RULE12] [RULE13]

  // flags, conditions, alert latch and results
  always @* begin
    loc_temp_d = loc_temp_q;
    rem_temp_d = rem_temp_q;
    cond_d = cond_q;
    if (conv_done) begin
      loc_temp_d = i_local_sample; // see [RULE1]
      rem_temp_d = rem_eff;
      cond_d = set_evt;
    end
    // read clears, persisting condition keeps, a new event wins over clear
    if (status_rd) begin
      flags_d = cond_q | set_evt; // see [RULE15]
    end else begin
      flags_d = flags_q | set_evt;
    end
    alert_d = alert_q;
    if (i_ara_strobe && alert_q) begin
      alert_d = |cond_q; // see [RULE20]
    end
    if (|set_evt) begin
      alert_d = 1'b1; // see [RULE16] [RULE18]
    end
  end

  // ****************************************************************
  // clocked state
  // ****************************************************************
  // registers; status has no write path
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_q <= ST_IDLE;
      rate_cnt_q <= 32'h0;
      conv_cnt_q <= 32'h0;
      rate_q <= `RST_RATE; // see [RULE3]
      loc_hi_q <= `RST_HIGH_LIMIT; // see [RULE5]
      loc_lo_q <= `RST_LOW_LIMIT;
      rem_hi_q <= `RST_HIGH_LIMIT;
      rem_lo_q <= `RST_LOW_LIMIT;
      cfg_mask_q <= 1'b0; // see [RULE22]
      cfg_hard_standby_pin_q <= 1'b0;
      loc_temp_q <= `RST_TEMP;
      rem_temp_q <= `RST_TEMP;
      open_cap_q <= 1'b0;
      short_cap_q <= 1'b0;
      flags_q <= `FLAGS_NONE; // see [RULE14]
      cond_q <= `FLAGS_NONE;
      alert_q <= 1'b0;
    end else begin
      state_q <= state_d;
      rate_cnt_q <= rate_cnt_d;
      conv_cnt_q <= conv_cnt_d;
      loc_temp_q <= loc_temp_d;
      rem_temp_q <= rem_temp_d;
      flags_q <= flags_d;
      cond_q <= cond_d;
      alert_q <= alert_d;
      // diode checked once per conversion, at its start
      if (start) begin
        open_cap_q <= diode_open; // see [RULE24]
        short_cap_q <= diode_short;
      end
      if (i_wr_strobe) begin
        case (i_wr_cmd)
          `CMD_CONFIG_WRITE: begin
            cfg_mask_q <= i_wr_data[`CFG_MASK_BIT]; // see [RULE22]
            cfg_hard_standby_pin_q <= i_wr_data[`CFG_HARD_STANDBY_PIN_BIT];
          end
          `CMD_RATE_WRITE: begin
            rate_q <= i_wr_data[`RATE_W-1:0]; // see [RULE2]
          end
          `CMD_LOCAL_HIGH_WRITE: begin
            loc_hi_q <= i_wr_data; // see [RULE6]
          end
          `CMD_LOCAL_LOW_WRITE: begin
            loc_lo_q <= i_wr_data;
          end
          `CMD_REMOTE_HIGH_WRITE: begin
            rem_hi_q <= i_wr_data;
          end
          `CMD_REMOTE_LOW_WRITE: begin
            rem_lo_q <= i_wr_data;
          end
          default: begin
            // read codes and reserved codes store nothing
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // read answers
  // ****************************************************************
  // answer one cycle after the strobe; alert response wins over a byte read
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      rd_data_q <= `RST_BYTE;
      rd_valid_q <= 1'b0;
      ara_ack_q <= 1'b0;
    end else begin
      rd_valid_q <= i_rd_strobe || (i_ara_strobe && alert_q);
      ara_ack_q <= i_ara_strobe && alert_q; // no answer when nothing is pending
      if (i_ara_strobe) begin
        rd_data_q <= alert_q ? {i_slave_addr, 1'b1} : `RST_BYTE; // see [RULE19]
      end else if (i_rd_strobe) begin
        case (i_rd_cmd)
          `CMD_LOCAL_TEMP_READ: rd_data_q <= loc_temp_q;
          `CMD_REMOTE_TEMP_READ: rd_data_q <= rem_temp_q;
          `CMD_STATUS_READ: rd_data_q <= status_byte;
          `CMD_CONFIG_READ: rd_data_q <= {cfg_mask_q, cfg_hard_standby_pin_q, 6'h00};
          `CMD_RATE_READ: rd_data_q <= {5'h00, rate_q};
          `CMD_LOCAL_HIGH_READ: rd_data_q <= loc_hi_q; // see [RULE6]
          `CMD_LOCAL_LOW_READ: rd_data_q <= loc_lo_q;
          `CMD_REMOTE_HIGH_READ: rd_data_q <= rem_hi_q;
          `CMD_REMOTE_LOW_READ: rd_data_q <= rem_lo_q;
          default: rd_data_q <= `RST_BYTE;
        endcase
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign o_rd_data = rd_data_q;
  assign o_rd_valid = rd_valid_q;
  assign o_ara_ack = ara_ack_q;
  // open drain: only ever pulls low, enable low while pulling
  assign o_alert_o = 1'b0; // see [RULE17]
  assign o_alert_oe_n = ~(alert_q & ~cfg_mask_q); // see [RULE17] [RULE22]
  assign o_local_temp_result = loc_temp_q;
  assign o_remote_temp_result = rem_temp_q;
endmodule

/* testbench/temp_monitor_limit_alert_chk.sv */
`timescale 1ns/1ps
// ********
// port checks for the limit and alert block
// ********
module temp_monitor_limit_alert_chk (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_wr_strobe,
  input wire logic [7:0] i_wr_cmd,
  input wire logic [7:0] i_wr_data,
  input wire logic i_rd_strobe,
  input wire logic [7:0] i_rd_cmd,
  input wire logic i_ara_strobe,
  input wire logic [6:0] i_slave_addr,
  input wire logic [7:0] i_local_sample,
  input wire logic [7:0] i_remote_sample,
  input wire logic i_hard_standby_pin_n,
  input wire logic [7:0] o_rd_data,
  input wire logic o_rd_valid,
  input wire logic o_ara_ack,
  input wire logic o_conv_start,
  input wire logic o_alert_o,
  input wire logic o_alert_oe_n,
  input wire logic [7:0] o_local_temp_result,
  input wire logic [7:0] o_remote_temp_result
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  a_alert_data_low: assert property (o_alert_o == 1'b0)
    else $error("alert data not low");
  a_read_answers: assert property (i_rd_strobe |=> o_rd_valid)
    else $error("read not answered");
  a_valid_cause: assert property (o_rd_valid |->
    $past(i_rd_strobe) || $past(i_ara_strobe))
    else $error("valid without request");
  a_ara_byte: assert property (o_ara_ack |-> o_rd_valid &&
    o_rd_data == {$past(i_slave_addr), 1'b1})
    else $error("alert response byte wrong");
  a_ack_cause: assert property (o_ara_ack |-> $past(i_ara_strobe))
    else $error("ack without response read");
  a_status_low_zero: assert property (i_rd_strobe && !i_ara_strobe &&
    i_rd_cmd == 8'h02 |=> o_rd_data[1:0] == 2'b00)
    else $error("status reserved bits set");
  a_rate_high_zero: assert property (i_rd_strobe && !i_ara_strobe &&
    i_rd_cmd == 8'h04 |=> o_rd_data[7:3] == 5'h00)
    else $error("rate upper bits set");
  a_hw_standby_blocks: assert property (
    !i_hard_standby_pin_n [*5] |-> !o_conv_start)
    else $error("start in hardware standby");
  a_busy_no_restart: assert property (o_conv_start |=> !o_conv_start [*8])
    else $error("start while busy");
  a_local_from_sample: assert property ($changed(o_local_temp_result) |->
    o_local_temp_result == $past(i_local_sample))
    else $error("local result not from sample");
  a_remote_from_sample: assert property ($changed(o_remote_temp_result) |->
    o_remote_temp_result == $past(i_remote_sample) || o_remote_temp_result == 8'h7f)
    else $error("remote result not from sample");
  // the pin may only let go after a response read or a mask write
  a_alert_release: assert property ($rose(o_alert_oe_n) |-> o_ara_ack ||
    ($past(i_wr_strobe) && $past(i_wr_cmd) == 8'h09 && $past(i_wr_data[7])))
    else $error("alert released without cause");
endmodule
bind temp_monitor_limit_alert temp_monitor_limit_alert_chk temp_monitor_limit_alert_chk_i (
  .i_clk, .i_sys_rst, .i_wr_strobe, .i_wr_cmd, .i_wr_data, .i_rd_strobe, .i_rd_cmd,
  .i_ara_strobe, .i_slave_addr, .i_local_sample, .i_remote_sample, .i_hard_standby_pin_n,
  .o_rd_data, .o_rd_valid, .o_ara_ack, .o_conv_start, .o_alert_o, .o_alert_oe_n,
  .o_local_temp_result, .o_remote_temp_result);

/* testbench/smbus_host_model.sv */
`timescale 1ns/1ps
// ********
// bus host: one byte transfer per call, driven on the falling edge
// ********
module smbus_host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_rd_data,
  input wire logic i_rd_valid,
  input wire logic i_ara_ack,
  output logic o_wr_strobe = 1'b0,
  output logic [7:0] o_wr_cmd = 8'h00,
  output logic [7:0] o_wr_data = 8'h00,
  output logic o_send_strobe = 1'b0,
  output logic [7:0] o_send_cmd = 8'h00,
  output logic o_rd_strobe = 1'b0,
  output logic [7:0] o_rd_cmd = 8'h00,
  output logic o_ara_strobe = 1'b0
);
  // released fields show the inverse so stale values never look valid
  task automatic wr_byte(input logic [7:0] cmd, input logic [7:0] dat);
    @(negedge i_clk);
    o_wr_cmd = cmd;
    o_wr_data = dat;
    o_wr_strobe = 1'b1;
    @(negedge i_clk);
    o_wr_strobe = 1'b0;
    o_wr_cmd = ~cmd;
    o_wr_data = ~dat;
  endtask
  // command-only transfer, no data byte follows
  task automatic send_byte(input logic [7:0] cmd);
    @(negedge i_clk);
    o_send_cmd = cmd;
    o_send_strobe = 1'b1;
    @(negedge i_clk);
    o_send_strobe = 1'b0;
    o_send_cmd = ~cmd;
  endtask
  // register read, or alert response read when ara is set
  task automatic rd_byte(input logic [7:0] cmd, input logic ara, output logic [7:0] got,
    output logic ok);
    @(negedge i_clk);
    o_rd_cmd = cmd;
    o_rd_strobe = !ara;
    o_ara_strobe = ara;
    @(negedge i_clk);
    got = i_rd_data;
    ok = ara ? i_ara_ack : i_rd_valid;
    o_rd_strobe = 1'b0;
    o_ara_strobe = 1'b0;
    o_rd_cmd = ~cmd;
  endtask
endmodule

/* testbench/temp_monitor_limit_alert_tb.sv */
`timescale 1ns/1ps
module temp_monitor_limit_alert_tb;
  // ********
  // shortened counts so the run stays brief
  // ********
  localparam int BASE = 1600;
  localparam int CONV = 50;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [6:0] addr = 7'h00;
  logic [7:0] loc = 8'h00;
  logic [7:0] rem = 8'h00;
  logic opened = 1'b0;
  logic shorted = 1'b0;
  logic hard_standby_pin_n = 1'b1;
  wire wr_strobe, send_strobe, rd_strobe, ara_strobe, rd_valid, ara_ack;
  wire conv_start, alert_o, alert_oe_n;
  wire [7:0] wr_cmd, wr_data, send_cmd, rd_cmd, rd_data, loc_res, rem_res;
  wire alert_ln = alert_oe_n ? 1'b1 : alert_o; // pull-up on the shared line
  int seed = 32'hcde66eff;
  int error_cnt = 0;
  int checks = 0;
  int starts = 0;
  int cyc = 0;
  int t0, s0;
  logic [7:0] got, l, r, d, fl;
  logic ok;
  logic [7:0] lim [4];
  logic [7:0] rst_tab [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h7f, 8'hc9, 8'h7f, 8'hc9};
  initial begin
    forever #4 clk = ~clk;
  end
  // count conversion starts and cycles for timing checks
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (conv_start) begin
      starts <= starts + 1;
    end
  end
  temp_monitor_limit_alert #(.BASE_PERIOD_CYCLES(BASE), .CONV_CYCLES(CONV))
    temp_monitor_limit_alert_i (.i_clk(clk), .i_sys_rst(sys_rst), .i_wr_strobe(wr_strobe),
    .i_wr_cmd(wr_cmd), .i_wr_data(wr_data), .i_send_strobe(send_strobe),
    .i_send_cmd(send_cmd), .i_rd_strobe(rd_strobe), .i_rd_cmd(rd_cmd),
    .i_ara_strobe(ara_strobe), .i_slave_addr(addr), .o_rd_data(rd_data),
    .o_rd_valid(rd_valid), .o_ara_ack(ara_ack), .i_local_sample(loc),
    .i_remote_sample(rem), .i_diode_open(opened), .i_diode_short(shorted),
    .i_hard_standby_pin_n(hard_standby_pin_n), .o_conv_start(conv_start), .o_alert_o(alert_o),
    .o_alert_oe_n(alert_oe_n), .o_local_temp_result(loc_res),
    .o_remote_temp_result(rem_res));
  smbus_host_model smbus_host_model_i (.i_clk(clk), .i_rd_data(rd_data),
    .i_rd_valid(rd_valid), .i_ara_ack(ara_ack), .o_wr_strobe(wr_strobe),
    .o_wr_cmd(wr_cmd), .o_wr_data(wr_data), .o_send_strobe(send_strobe),
    .o_send_cmd(send_cmd), .o_rd_strobe(rd_strobe), .o_rd_cmd(rd_cmd),
    .o_ara_strobe(ara_strobe));
  // ********
  // helpers
  // ********
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // signed compare of both channels against the limits in use
  function automatic logic [7:0] exp_status(input logic [7:0] a, input logic [7:0] b);
    exp_status = {1'b0, $signed(a) >= $signed(lim[0]), $signed(a) <= $signed(lim[1]),
      $signed(b) >= $signed(lim[2]), $signed(b) <= $signed(lim[3]), 3'b000};
  endfunction
  task automatic wr(input logic [7:0] cmd, input logic [7:0] dat);
    smbus_host_model_i.wr_byte(cmd, dat);
  endtask
  task automatic rd(input logic [7:0] cmd, input logic [7:0] e);
    smbus_host_model_i.rd_byte(cmd, 1'b0, got, ok);
    chk(ok, 1'b1);
    chk(got, e);
  endtask
  task automatic ara(input logic ack_e, input logic alert_e);
    smbus_host_model_i.rd_byte(8'h00, 1'b1, got, ok);
    chk(ok, ack_e);
    if (ack_e) begin
      chk(got, {addr, 1'b1});
    end
    chk(alert_ln, alert_e);
  endtask
  task automatic set_lim;
    for (int j = 0; j < 4; j++) begin
      wr(8'h0b + 8'(j), lim[j]);
      rd(8'h05 + 8'(j), lim[j]);
    end
  endtask
  // one-shot with the samples set, then wait out the conversion
  task automatic convert(input logic [7:0] a, input logic [7:0] b, input int n);
    int s;
    s = starts;
    loc = a;
    rem = b;
    smbus_host_model_i.send_byte(8'h0f);
    repeat (CONV + 10) @(negedge clk);
    chk(starts - s, n);
  endtask
  task automatic wait_start;
    int s;
    s = starts;
    for (int k = 0; k < 4000 && starts == s; k++) begin
      @(negedge clk);
    end
    chk(starts != s, 1'b1);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // watchdog sized well above the expected run
  initial begin
    #400000;
    error_cnt++;
    print_verdict();
  end
  // ********
  // main sequence
  // ********
  initial begin
    repeat (8) @(negedge clk);
    sys_rst = 1'b0;
    addr = 7'($random(seed));
    for (int i = 0; i < 9; i++) begin
      rd(8'(i), rst_tab[i]);
    end
    wr(8'h09, 8'h40);
    rd(8'h03, 8'h40);
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      wr(8'h0a, d);
      rd(8'h04, {5'h00, d[2:0]});
    end
    wr(8'h02, 8'hff);
    rd(8'h02, 8'h00);
    // limit trips: first two rounds sit exactly on both limits
    for (int i = 0; i < 8; i++) begin
      l = 8'($random(seed));
      r = 8'($random(seed));
      for (int j = 0; j < 4; j++) begin
        lim[j] = (i < 2) ? ((j < 2) ? l : r) : 8'($random(seed));
      end
      set_lim();
      fl = exp_status(l, r);
      convert(l, r, 1);
      chk(loc_res, l);
      chk(rem_res, r);
      rd(8'h02, fl);
      chk(alert_ln, fl == 8'h00);
      rd(8'h02, fl);
      ara(fl != 8'h00, fl == 8'h00);
      lim = '{8'h7f, 8'h80, 8'h7f, 8'h80};
      set_lim();
      convert(8'h00, 8'h00, 1);
      rd(8'h02, fl);
      rd(8'h02, 8'h00);
      chk(alert_ln, fl == 8'h00);
      ara(fl != 8'h00, 1'b1);
    end
    // hardware standby blocks, then aborts a running conversion
    hard_standby_pin_n = 1'b0;
    repeat (6) @(negedge clk);
    convert(8'h11, 8'h22, 0);
    hard_standby_pin_n = 1'b1;
    repeat (6) @(negedge clk);
    smbus_host_model_i.send_byte(8'h0f);
    repeat (20) @(negedge clk);
    hard_standby_pin_n = 1'b0;
    repeat (CONV + 10) @(negedge clk);
    chk(loc_res, 8'h00);
    chk(rem_res, 8'h00);
    rd(8'h02, 8'h00);
    hard_standby_pin_n = 1'b1;
    // free-running interval for rate codes 4 down to 0, ending on code zero
    wr(8'h09, 8'h00);
    for (int c = 4; c >= 0; c--) begin
      wr(8'h0a, 8'(c));
      wait_start();
      t0 = cyc;
      wait_start();
      chk(cyc - t0, BASE >> c);
    end
    repeat (CONV + 10) @(negedge clk);
    s0 = starts;
    smbus_host_model_i.send_byte(8'h0f);
    chk(starts, s0 + 1);
    rd(8'h02, 8'h80);
    repeat (20) @(negedge clk);
    smbus_host_model_i.send_byte(8'h0f);
    chk(starts, s0 + 1);
    repeat (CONV + 10) @(negedge clk);
    rd(8'h02, 8'h00);
    wr(8'h09, 8'h40);
    repeat (CONV + 10) @(negedge clk);
    // diode faults: shorted first, then open
    for (int f = 0; f < 2; f++) begin
      shorted = (f == 0);
      opened = (f == 1);
      repeat (6) @(negedge clk);
      convert(8'h00, 8'h00, 1);
      chk(rem_res, 8'h7f);
      rd(8'h02, opened ? 8'h14 : 8'h10);
    end
    chk(alert_ln, 1'b0);
    wr(8'h09, 8'hc0);
    @(negedge clk);
    chk(alert_ln, 1'b1);
    wr(8'h09, 8'h40);
    @(negedge clk);
    chk(alert_ln, 1'b0);
    print_verdict();
  end
endmodule
